// ==== rtl/ctre_map.svh ====
// How it works
// - touched when drop exceeds touch threshold
// - small drift moves calibrated reference
// - delay tuning is 6 bits, 0.5 pF steps
// - raw view follows measured impedance live
// - impedance 13 bits, low 4 bits residue
// - calibrated view read only, self updated
// - locked view captured once per selection, then frozen
// - engine position from neighbour capacitance ratio
// - setup bit 6 gives overwritten position byte
// - bit 6 clear buffers full packets
// - bits 5 and 4 enable noise filters
// - bits 3 and 2 select wheel layout
// - setup bit 1 enables engine 2
// - config bits 7:5 hold count minus one, values below 2 give three
// - config bits 4:0 hold first channel
// - status bits 1 and 0 flag multi-touch
// - three byte packets, four entry buffer
// - byte three holds touch flag and stamp
// - stamp unit 8 ms or 0.25 ms
`ifndef CTRE_MAP_SVH
`define CTRE_MAP_SVH

// register offsets
`define CTRE_OFS_SETUP     8'h80
`define CTRE_OFS_ENG1_CH   8'h81
`define CTRE_OFS_ENG2_CH   8'h82
`define CTRE_OFS_MULTI     8'h83
`define CTRE_OFS_ENG1_PKT  8'h84
`define CTRE_OFS_ENG2_PKT  8'h87
`define CTRE_OFS_DTYPE     8'h7C
`define CTRE_OFS_TOUCH     8'hB4
`define CTRE_OFS_CHDATA    8'hC0
`define CTRE_OFS_CHEND     8'hEF

// setup register field positions
`define CTRE_BIT_POSONLY   6
`define CTRE_BIT_FILT2     5
`define CTRE_BIT_FILT1     4
`define CTRE_BIT_WHEEL2    3
`define CTRE_BIT_WHEEL1    2
`define CTRE_BIT_ON2       1
`define CTRE_BIT_ON1       0

// channel data view selectors
`define CTRE_DT_TTHR       8'h01
`define CTRE_DT_DTHR       8'h02
`define CTRE_DT_DELAY      8'h03
`define CTRE_DT_IMP        8'h04
`define CTRE_DT_CAL        8'h05
`define CTRE_DT_LOCK       8'h06

// field widths and reset values
`define CTRE_IMP_W         13
`define CTRE_IMP_RESIDUE   4
`define CTRE_DLY_W         6
`define CTRE_THR_W         9
`define CTRE_RST_BYTE      8'h00
`define CTRE_PKT_DEPTH     4

// time stamp units
`define CTRE_CLK_NS        10
`define CTRE_TS_MAF_NS     8000000
`define CTRE_TS_RAW_NS     250000

`endif

// ==== rtl/ctre_pkg.sv ====
`default_nettype none
package ctre_pkg;
	// one ratio engine output packet, byte three on top
	typedef struct packed {
		logic       touch;
		logic [6:0] stamp;
		logic [7:0] move;
		logic [7:0] pos;
	} ctre_pkt_t;

	// engine channel group setup
	typedef struct packed {
		logic [2:0] range;
		logic [4:0] start;
	} ctre_chcfg_t;
endpackage
`default_nettype wire

// ==== rtl/ctre_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctre_fifo #(
	parameter int W     = 24,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// fill side
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	// drain side
	output logic              outValid,
	input  wire logic         outReady,
	output logic      [W-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} ctre_fifo_st_t;

	ctre_fifo_st_t s_r;
	ctre_fifo_st_t s_nxt;
	logic          doPush;
	logic          doPop;

	// handshakes straight from the fill count
	assign inReady  = (s_r.cnt != (AW+1)'(DEPTH));
	assign outValid = (s_r.cnt != '0);
	assign outData  = s_r.mem[s_r.rp];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	// pointer and count update, pointers wrap for any depth
	always_comb begin
		s_nxt = s_r;
		if (doPush) begin
			s_nxt.mem[s_r.wp] = inData;
			s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
		end
		if (doPop) begin
			s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
		end
		if (doPush && !doPop) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end else if (doPop && !doPush) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule // ctre_fifo
`default_nettype wire

// ==== rtl/ctre_ratio_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctre_ratio_calc #(
	parameter int NCH = 24
) (
	// per channel capacitance rise and touch state
	input  wire logic [NCH-1:0][12:0]  delta,
	input  wire logic [NCH-1:0]        touched,
	// group setup
	input  wire ctre_pkg::ctre_chcfg_t cfg,
	input  wire logic                  wheel,
	// result
	output logic      [7:0]            pos,
	output logic                       anyTouch,
	output logic                       multiTouch
);
	logic [7:0][12:0] sig;
	logic [7:0]       tch;
	logic [3:0]       n;
	logic [2:0]       k;
	logic [2:0]       kl;
	logic [2:0]       kr;
	logic [12:0]      sl;
	logic [12:0]      sr;
	logic [12:0]      sn;
	logic             right;
	logic [13:0]      sum;
	logic [6:0]       off;
	logic [9:0]       span;
	logic [9:0]       fine;
	logic [17:0]      scaled;
	logic [3:0]       edges;

	// gather group, find peak, interpolate towards stronger neighbour
	always_comb begin
		n = (cfg.range < 3'd2) ? 4'd3 : {1'b0, cfg.range} + 4'd1;
		sig = '0;
		tch = '0;
		k = '0;
		edges = '0;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < n && int'(cfg.start) + i < NCH) begin
				sig[i] = delta[int'(cfg.start) + i];
				tch[i] = touched[int'(cfg.start) + i];
			end
			if (sig[i] > sig[k]) begin
				k = 3'(i);
			end
			if (tch[i] && (i == 0 || !tch[(i + 7) % 8])) begin
				edges = edges + 4'd1;
			end
		end
		kl = (k == 3'd0) ? 3'(n - 4'd1) : k - 3'd1;
		kr = ({1'b0, k} == n - 4'd1) ? 3'd0 : k + 3'd1;
		sl = (k == 3'd0 && !wheel) ? '0 : sig[kl];
		sr = ({1'b0, k} == n - 4'd1 && !wheel) ? '0 : sig[kr];
		right = (sr >= sl);
		sn = right ? sr : sl;
		sum = {1'b0, sig[k]} + {1'b0, sn};
		// ratio of neighbour to peak plus neighbour, 64 steps per channel
		off = (sum == '0) ? '0 : 7'((19'(sn) << 6) / 19'(sum));
		span = wheel ? {n, 6'b0} : {n - 4'd1, 6'b0};
		if (right) begin
			fine = 10'({k, 6'b0}) + 10'(off);
		end else if (k == 3'd0) begin
			fine = span - 10'(off);
		end else begin
			fine = 10'({k, 6'b0}) - 10'(off);
		end
		if (wheel && fine >= span) begin
			fine = fine - span;
		end
		scaled = (18'(fine) * 18'd255) / 18'(span);
		pos = (scaled > 18'd255) ? 8'hFF : scaled[7:0];
		anyTouch = |tch;
		multiTouch = (edges > 4'd1);
	end
endmodule // ctre_ratio_calc
`default_nettype wire

// ==== rtl/ctre_engine_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ctre_map.svh"
module ctre_engine_top #(
	parameter int NCH        = 24,
	parameter int TS_MAF_CYC = `CTRE_TS_MAF_NS / `CTRE_CLK_NS,
	parameter int TS_RAW_CYC = `CTRE_TS_RAW_NS / `CTRE_CLK_NS,
	parameter int PKT_DEPTH  = `CTRE_PKT_DEPTH
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// byte register port behind the serial interface
	input  wire logic [7:0]                    regAddr,
	input  wire logic                          regWr,
	input  wire logic [7:0]                    regWrData,
	input  wire logic                          regRd,
	output logic      [7:0]                    regRdData,
	output logic                               regRdValid,
	// measurement front end
	input  wire logic [NCH*`CTRE_IMP_W-1:0]    impIn,
	input  wire logic                          impValid,
	input  wire logic                          medianAverageFilter,
	output logic      [NCH*`CTRE_DLY_W-1:0]    chanDelay,
	output logic      [NCH-1:0]                liveTouchStatus,
	// event pulses to the interrupt controller
	output logic      [1:0]                    sliderEventFlag
);
	localparam int IW = `CTRE_IMP_W;
	localparam int DW = `CTRE_DLY_W;
	localparam int TW = `CTRE_THR_W;

	typedef struct packed {
		logic [7:0]                       setup;
		ctre_pkg::ctre_chcfg_t [1:0]      chCfg;
		logic [7:0]                       dataType;
		logic [NCH-1:0][TW-1:0]           tThr;
		logic [NCH-1:0][TW-1:0]           dThr;
		logic [NCH-1:0][DW-1:0]           delay;
		logic [NCH-1:0][IW-1:0]           imp;
		logic [NCH-1:0][IW-1:0]           calRef;
		logic [NCH-1:0][IW-1:0]           locked;
		logic                             lockHeld;
		logic                             engStep;
		logic [NCH-1:0]                   touch;
		logic [19:0]                      preCnt;
		logic [1:0][6:0]                  tsCnt;
		logic [1:0][7:0]                  prevPos;
		logic [1:0][7:0]                  posByte;
		logic [1:0]                       wasTouch;
		logic [1:0]                       multi;
		logic [1:0]                       pendV;
		logic [1:0]                       evt;
		ctre_pkg::ctre_pkt_t [1:0]        pend;
		logic [7:0]                       rdData;
		logic                             rdValid;
	} ctre_top_st_t;

	ctre_top_st_t                  s_r;
	ctre_top_st_t                  s_nxt;
	logic [NCH-1:0][IW-1:0]        impNow;
	logic [NCH-1:0][12:0]          delta;
	logic [1:0][7:0]               posNew;
	logic [1:0]                    touchNew;
	logic [1:0]                    multiNew;
	logic [1:0]                    fifoInReady;
	logic [1:0]                    fifoOutValid;
	logic [1:0]                    fifoPop;
	ctre_pkg::ctre_pkt_t [1:0]     fifoHead;
	logic [1:0]                    engOn;
	logic [1:0]                    engWheel;
	logic [1:0]                    engFilt;
	logic                          posOnly;
	logic [19:0]                   tickLim;
	logic                          tick;
	logic [7:0]                    chOfs;
	logic [4:0]                    chIdx;
	logic                          chOk;
	logic [15:0]                   chView;
	logic [15:0]                   chNew;

	// setup register fields
	assign engOn    = {s_r.setup[`CTRE_BIT_ON2], s_r.setup[`CTRE_BIT_ON1]};
	assign engWheel = {s_r.setup[`CTRE_BIT_WHEEL2], s_r.setup[`CTRE_BIT_WHEEL1]};
	assign engFilt  = {s_r.setup[`CTRE_BIT_FILT2], s_r.setup[`CTRE_BIT_FILT1]};
	assign posOnly  = s_r.setup[`CTRE_BIT_POSONLY];

	// outputs straight from state
	assign regRdData       = s_r.rdData;
	assign regRdValid      = s_r.rdValid;
	assign chanDelay       = s_r.delay;
	assign liveTouchStatus = s_r.touch;
	assign sliderEventFlag = s_r.evt;

	// stamp prescaler, unit depends on the median averaging filter
	assign tickLim = medianAverageFilter ? 20'(TS_MAF_CYC - 1) : 20'(TS_RAW_CYC - 1);
	assign tick    = (s_r.preCnt >= tickLim);

	// capacitance rise seen as impedance drop below the reference
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			impNow[i] = impIn[i*IW +: IW];
			delta[i] = (s_r.calRef[i] > s_r.imp[i]) ? s_r.calRef[i] - s_r.imp[i] : '0;
		end
	end

	// channel data window decode and current view of the addressed channel
	always_comb begin
		chOfs = regAddr - `CTRE_OFS_CHDATA;
		chIdx = chOfs[5:1];
		chOk = (regAddr >= `CTRE_OFS_CHDATA) && (regAddr <= `CTRE_OFS_CHEND)
			&& (int'(chIdx) < NCH);
		chView = '0;
		if (chOk) begin
			unique case (s_r.dataType)
				`CTRE_DT_TTHR:  chView = 16'(s_r.tThr[chIdx]);
				`CTRE_DT_DTHR:  chView = 16'(s_r.dThr[chIdx]);
				`CTRE_DT_DELAY: chView = 16'(s_r.delay[chIdx]);
				`CTRE_DT_IMP:   chView = 16'(s_r.imp[chIdx]);
				`CTRE_DT_CAL:   chView = 16'(s_r.calRef[chIdx]);
				`CTRE_DT_LOCK:  chView = 16'(s_r.locked[chIdx]);
				default:        chView = '0;
			endcase
		end
		chNew = chOfs[0] ? {regWrData, chView[7:0]} : {chView[15:8], regWrData};
	end

	// one ratio engine calculator and one packet buffer per engine
	for (genvar e = 0; e < 2; e++) begin : gEng
		ctre_ratio_calc #(
			.NCH        (NCH)
		) uCalc (
			.delta      (delta),
			.touched    (s_r.touch),
			.cfg        (s_r.chCfg[e]),
			.wheel      (engWheel[e]),
			.pos        (posNew[e]),
			.anyTouch   (touchNew[e]),
			.multiTouch (multiNew[e])
		);

		ctre_fifo #(
			.W        ($bits(ctre_pkg::ctre_pkt_t)),
			.DEPTH    (PKT_DEPTH)
		) uBuf (
			.clk      (clk),
			.rst_n    (rst_n),
			.inValid  (s_r.pendV[e]),
			.inReady  (fifoInReady[e]),
			.inData   (s_r.pend[e]),
			.outValid (fifoOutValid[e]),
			.outReady (fifoPop[e]),
			.outData  (fifoHead[e])
		);

		// reading the third packet byte releases the buffered packet
		assign fifoPop[e] = regRd && !posOnly && fifoOutValid[e]
			&& (regAddr == ((e == 0) ? `CTRE_OFS_ENG1_PKT : `CTRE_OFS_ENG2_PKT) + 8'h02);
	end

	// next state: register access, channel sampling, engines
	always_comb begin
		logic [7:0]  fpos;
		logic [7:0]  pkOfs;
		logic [23:0] pkWord;
		logic [IW:0] diff;
		s_nxt = s_r;
		fpos = '0;
		pkOfs = '0;
		pkWord = '0;
		diff = '0;
		s_nxt.rdValid = 1'b0;
		s_nxt.evt = '0;
		// engines run one cycle after a frame, on the fresh touch and reference
		s_nxt.engStep = impValid;

		// register writes, read-only views ignore writes
		if (regWr) begin
			unique case (regAddr) inside
				`CTRE_OFS_SETUP:   s_nxt.setup = regWrData;
				`CTRE_OFS_ENG1_CH: s_nxt.chCfg[0] = regWrData;
				`CTRE_OFS_ENG2_CH: s_nxt.chCfg[1] = regWrData;
				`CTRE_OFS_DTYPE:   s_nxt.dataType = regWrData;
				[`CTRE_OFS_CHDATA:`CTRE_OFS_CHEND]: begin
					if (chOk) begin
						unique case (s_r.dataType)
							`CTRE_DT_TTHR:  s_nxt.tThr[chIdx] = chNew[TW-1:0];
							`CTRE_DT_DTHR:  s_nxt.dThr[chIdx] = chNew[TW-1:0];
							`CTRE_DT_DELAY: s_nxt.delay[chIdx] = chNew[DW-1:0];
							default:        s_nxt.rdValid = 1'b0;
						endcase
					end
				end
				default: s_nxt.rdValid = 1'b0;
			endcase
		end

		// register reads, unmapped addresses read zero
		if (regRd) begin
			s_nxt.rdValid = 1'b1;
			s_nxt.rdData = '0;
			unique case (regAddr) inside
				`CTRE_OFS_SETUP:   s_nxt.rdData = s_r.setup;
				`CTRE_OFS_ENG1_CH: s_nxt.rdData = s_r.chCfg[0];
				`CTRE_OFS_ENG2_CH: s_nxt.rdData = s_r.chCfg[1];
				`CTRE_OFS_MULTI:   s_nxt.rdData = {6'b0, s_r.multi};
				`CTRE_OFS_DTYPE:   s_nxt.rdData = s_r.dataType;
				[`CTRE_OFS_TOUCH:`CTRE_OFS_TOUCH + 8'h02]: begin
					s_nxt.rdData = 8'(32'(s_r.touch) >> (8 * int'(regAddr - `CTRE_OFS_TOUCH)));
				end
				[`CTRE_OFS_ENG1_PKT:`CTRE_OFS_ENG2_PKT + 8'h02]: begin
					if (regAddr >= `CTRE_OFS_ENG2_PKT) begin
						pkOfs = regAddr - `CTRE_OFS_ENG2_PKT;
						pkWord = posOnly ? {16'b0, s_r.posByte[1]}
							: (fifoOutValid[1] ? fifoHead[1] : '0);
					end else begin
						pkOfs = regAddr - `CTRE_OFS_ENG1_PKT;
						pkWord = posOnly ? {16'b0, s_r.posByte[0]}
							: (fifoOutValid[0] ? fifoHead[0] : '0);
					end
					s_nxt.rdData = pkWord[8*pkOfs[1:0] +: 8];
				end
				[`CTRE_OFS_CHDATA:`CTRE_OFS_CHEND]: begin
					s_nxt.rdData = chOfs[0] ? chView[15:8] : chView[7:0];
				end
				default: s_nxt.rdData = '0;
			endcase
		end

		// locked view: one snapshot per selection, freed by any other view
		if (s_r.dataType != `CTRE_DT_LOCK) begin
			s_nxt.lockHeld = 1'b0;
		end else if (!s_r.lockHeld) begin
			s_nxt.locked = s_r.imp;
			s_nxt.lockHeld = 1'b1;
		end

		// new measurement frame: raw view, drift tracking, touch decision
		if (impValid) begin
			for (int i = 0; i < NCH; i++) begin
				s_nxt.imp[i] = impNow[i];
				diff = (impNow[i] > s_r.calRef[i]) ? {1'b0, impNow[i]} - {1'b0, s_r.calRef[i]}
					: {1'b0, s_r.calRef[i]} - {1'b0, impNow[i]};
				if (s_r.calRef[i] == '0) begin
					s_nxt.calRef[i] = impNow[i];
				end else if (diff < (IW+1)'(s_r.dThr[i]) && diff != '0) begin
					s_nxt.calRef[i] = (impNow[i] > s_r.calRef[i]) ? s_r.calRef[i] + 1'b1
						: s_r.calRef[i] - 1'b1;
				end
				s_nxt.touch[i] = (s_r.calRef[i] > impNow[i])
					&& (diff > (IW+1)'(s_r.tThr[i]));
			end
		end

		// stamp prescaler
		s_nxt.preCnt = tick ? '0 : s_r.preCnt + 20'd1;

		// the two ratio engines
		for (int e = 0; e < 2; e++) begin
			if (tick && s_r.tsCnt[e] != 7'h7F) begin
				s_nxt.tsCnt[e] = s_r.tsCnt[e] + 7'd1;
			end
			if (s_r.pendV[e] && fifoInReady[e]) begin
				s_nxt.pendV[e] = 1'b0;
			end
			fpos = (engFilt[e] && s_r.wasTouch[e])
				? 8'(({1'b0, s_r.prevPos[e]} + {1'b0, posNew[e]}) >> 1) : posNew[e];
			if (!engOn[e]) begin
				s_nxt.wasTouch[e] = 1'b0;
				s_nxt.multi[e] = 1'b0;
			end else if (s_r.engStep) begin
				s_nxt.multi[e] = multiNew[e];
				if (posOnly) begin
					if (touchNew[e]) begin
						s_nxt.posByte[e] = fpos;
						s_nxt.evt[e] = !s_r.wasTouch[e];
					end
				end else begin
					if ((touchNew[e] || s_r.wasTouch[e]) && !s_nxt.pendV[e]) begin
						s_nxt.pend[e].touch = touchNew[e];
						s_nxt.pend[e].stamp = s_r.tsCnt[e];
						s_nxt.pend[e].move = touchNew[e] ? fpos - s_r.prevPos[e] : 8'h00;
						s_nxt.pend[e].pos = touchNew[e] ? fpos : s_r.prevPos[e];
						s_nxt.pendV[e] = 1'b1;
						// a tick landing on the build edge counts for the next stamp
						s_nxt.tsCnt[e] = tick ? 7'd1 : 7'd0;
					end
					s_nxt.evt[e] = s_r.wasTouch[e] && !touchNew[e];
				end
				if (touchNew[e]) begin
					s_nxt.prevPos[e] = fpos;
				end
				s_nxt.wasTouch[e] = touchNew[e];
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule // ctre_engine_top
`default_nettype wire

// ==== dv/ctre_engine_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctre_engine_asserts #(
	parameter int NCH = 24
) (
	// clock and reset
	input wire logic             clk,
	input wire logic             rst_n,
	// register port
	input wire logic [7:0]       regAddr,
	input wire logic             regWr,
	input wire logic [7:0]       regWrData,
	input wire logic             regRd,
	input wire logic [7:0]       regRdData,
	input wire logic             regRdValid,
	// front end and events
	input wire logic             impValid,
	input wire logic [NCH*6-1:0] chanDelay,
	input wire logic [NCH-1:0]   liveTouchStatus,
	input wire logic [1:0]       sliderEventFlag
);
	// shadow of the data type and setup bytes the host wrote
	logic [7:0] dtype_r;
	logic [7:0] setup_r;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dtype_r <= 8'h00;
			setup_r <= 8'h00;
		end else if (regWr) begin
			if (regAddr == 8'h7C) dtype_r <= regWrData;
			if (regAddr == 8'h80) setup_r <= regWrData;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// a read strobe, and a config write read back two cycles on
	sequence readTaken;
		regRd;
	endsequence
	sequence cfgWriteThenRead;
		regWr && regAddr inside {8'h80, 8'h81, 8'h82} ##1 !regWr
			##1 regRd && !regWr && regAddr == $past(regAddr, 2);
	endsequence

	rd_answer_a: assert property (readTaken |=> regRdValid)
		else $error("read not answered next cycle");
	rd_hold_a: assert property (!regRd |=> $stable(regRdData))
		else $error("read data moved without a read");
	cfg_back_a: assert property (cfgWriteThenRead |=> regRdData == $past(regWrData, 3))
		else $error("setup byte not read back");
	multi_resv_a: assert property (regRd && regAddr == 8'h83 |=> regRdData[7:2] == 6'h00)
		else $error("multi-touch reserved bits set");
	posonly_zero_a: assert property (regRd && setup_r[6] && regAddr inside {8'h85, 8'h86, 8'h88, 8'h89}
		|=> regRdData == 8'h00)
		else $error("position mode packet byte not zero");
	delay_write_a: assert property (regWr && dtype_r == 8'h03 && regAddr == 8'hC0
		|=> chanDelay[5:0] == 6'($past(regWrData)))
		else $error("channel delay not taken");
	delay_hold_a: assert property (!regWr |=> $stable(chanDelay))
		else $error("channel delay moved without a write");
	touch_frame_a: assert property (!impValid |=> $stable(liveTouchStatus))
		else $error("touch status moved without a frame");
	event_src_a: assert property (sliderEventFlag[0] |-> $past(impValid, 2))
		else $error("event without a frame two cycles before");
	event_pulse_a: assert property (sliderEventFlag[1] |=> !sliderEventFlag[1])
		else $error("event longer than one cycle");
endmodule // ctre_engine_asserts
`default_nettype wire

// ==== dv/ctre_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctre_host_model (
	// clock
	input  wire logic       clk,
	// register port
	output logic      [7:0] regAddr,
	output logic            regWr,
	output logic      [7:0] regWrData,
	output logic            regRd,
	input  wire logic [7:0] regRdData,
	input  wire logic       regRdValid
);
	// idle bus at time zero
	initial begin
		regAddr = 8'h00;
		regWr = 1'b0;
		regWrData = 8'h00;
		regRd = 1'b0;
	end
	// one byte write; idle lines show the inverse afterwards
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		regAddr = a;
		regWrData = d;
		regWr = 1'b1;
		@(posedge clk);
		#1;
		regWr = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask
	// one byte read; the answer is settled one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		regAddr = a;
		regRd = 1'b1;
		@(posedge clk);
		#1;
		regRd = 1'b0;
		regAddr = ~a;
		d = regRdData;
	endtask
endmodule // ctre_host_model
`default_nettype wire

// ==== dv/ctre_engine_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctre_engine_top_tb;
	typedef struct packed {
		logic [7:0] wa;
		logic [7:0] wd;
		logic [7:0] ra;
		logic [7:0] exp;
	} ctre_row_t;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic [103:0] impIn = '0;
	logic [103:0] f;
	logic         impValid = 1'b0;
	logic         medianAverageFilter = 1'b0;
	logic [7:0]   regAddr, regWrData, regRdData, g, h, p0, p1, p2;
	logic         regWr, regRd, regRdValid;
	logic [47:0]  chanDelay;
	logic [7:0]   liveTouchStatus;
	logic [1:0]   sliderEventFlag;
	int           mismatches = 0;
	int           checks = 0;
	int           cycles = 0;
	int           ev1 = 0;
	int           ev2 = 0;
	ctre_row_t    rows [13];

	always #5 clk = ~clk;

	ctre_engine_top #(.NCH(8), .TS_MAF_CYC(20), .TS_RAW_CYC(5)) i_ctre_engine_top (
		.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr),
		.regWrData(regWrData), .regRd(regRd), .regRdData(regRdData),
		.regRdValid(regRdValid), .impIn(impIn), .impValid(impValid),
		.medianAverageFilter(medianAverageFilter), .chanDelay(chanDelay),
		.liveTouchStatus(liveTouchStatus), .sliderEventFlag(sliderEventFlag));
	ctre_host_model i_ctre_host_model (
		.clk(clk), .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData),
		.regRd(regRd), .regRdData(regRdData), .regRdValid(regRdValid));

	// cycle ceiling and engine event counts
	always @(negedge clk) begin
		cycles++;
		if (sliderEventFlag[0] === 1'b1) ev1++;
		if (sliderEventFlag[1] === 1'b1) ev2++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_ctre_host_model.wr(a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		i_ctre_host_model.rd(a, g);
		chk(g, exp);
	endtask
	// one packet, bytes in the order that pops it
	task automatic pop();
		i_ctre_host_model.rd(8'h84, p0);
		i_ctre_host_model.rd(8'h85, p1);
		i_ctre_host_model.rd(8'h86, p2);
	endtask
	// touched channels drop by 0x100 from the 0x1000 rest level
	function automatic logic [103:0] mk(input logic [7:0] t);
		logic [103:0] v;
		for (int i = 0; i < 8; i++)
			v[13*i +: 13] = t[i] ? 13'h0F00 : 13'h1000;
		return v;
	endfunction
	// frame strobe for one edge; frames sit gap+2 edges apart
	task automatic frame(input logic [103:0] v, input int gap);
		@(posedge clk);
		#1;
		impIn = v;
		impValid = 1'b1;
		@(posedge clk);
		#1;
		impValid = 1'b0;
		repeat (gap) @(posedge clk);
	endtask

	initial begin
		rows = '{'{8'h80, 8'h7F, 8'h80, 8'h7F}, '{8'h81, 8'h45, 8'h81, 8'h45},
			'{8'h82, 8'hA3, 8'h82, 8'hA3}, '{8'h83, 8'hFF, 8'h83, 8'h00},
			'{8'h84, 8'h5A, 8'h86, 8'h00}, '{8'h10, 8'h5A, 8'h10, 8'h00},
			'{8'h7C, 8'h03, 8'h7C, 8'h03}, '{8'hC0, 8'hFF, 8'hC0, 8'h3F},
			'{8'hC1, 8'hFF, 8'hC1, 8'h00}, '{8'h7C, 8'h01, 8'hC1, 8'h00},
			'{8'hC1, 8'hFF, 8'hC1, 8'h01}, '{8'h7C, 8'h04, 8'hC0, 8'h00},
			'{8'hC0, 8'h55, 8'hC0, 8'h00}};
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rdc(rows[i].ra, rows[i].exp);
		end
		chk({2'b00, chanDelay[5:0]}, 8'h3F);
		// second reset in mid-run clears the engine registers
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		for (int a = 8'h80; a < 8'h8A; a++) rdc(8'(a), 8'h00);
		chk(chanDelay[7:0], 8'h00);
		// touch thresholds everywhere, drift threshold on channel 0
		wr(8'h7C, 8'h01);
		for (int c = 0; c < 8; c++) wr(8'(8'hC0 + 2 * c), 8'h40);
		wr(8'h7C, 8'h02);
		wr(8'hC0, 8'h10);
		// groups first, then both engines enabled in one write
		wr(8'h81, 8'h40);
		wr(8'h82, 8'h44);
		wr(8'h80, 8'h03);
		frame(mk(8'h00), 3);
		f = mk(8'h00);
		f[12:0] = 13'h1008;
		frame(f, 3);
		wr(8'h7C, 8'h05);
		rdc(8'hC0, 8'h01);
		rdc(8'hC1, 8'h10);
		wr(8'hC0, 8'h55);
		rdc(8'hC0, 8'h01);
		// finger on channel 1
		frame(mk(8'h02), 3);
		chk(liveTouchStatus, 8'h02);
		wr(8'h7C, 8'h04);
		i_ctre_host_model.rd(8'hC2, g);
		i_ctre_host_model.rd(8'hC3, h);
		chk(h, 8'h0F);
		chk(8'({h, g} >> 4), 8'hF0);
		pop();
		chk({7'h00, p2[7]}, 8'h01);
		// locked view survives the release frame
		wr(8'h7C, 8'h06);
		frame(mk(8'h00), 3);
		rdc(8'hC3, 8'h0F);
		chk(8'(ev1), 8'h01);
		pop();
		chk({7'h00, p2[7]}, 8'h00);
		rdc(8'h86, 8'h00);
		// overfill the buffer, then drain it
		repeat (6) frame(mk(8'h02), 3);
		repeat (4) begin
			pop();
			chk({7'h00, p2[7]}, 8'h01);
		end
		pop();
		pop();
		chk(p2, 8'h00);
		// 40 cycles between packets: 8 short ticks, then 2 long ticks
		frame(mk(8'h02), 38);
		frame(mk(8'h02), 38);
		pop();
		pop();
		chk(p2, 8'h88);
		@(posedge clk);
		#1;
		medianAverageFilter = 1'b1;
		frame(mk(8'h02), 38);
		frame(mk(8'h02), 38);
		pop();
		pop();
		chk(p2, 8'h82);
		// position mode: event on a fresh touch at the slider's far end
		wr(8'h80, 8'h43);
		frame(mk(8'h00), 3);
		frame(mk(8'h04), 3);
		chk(8'(ev1), 8'h02);
		rdc(8'h84, 8'hFF);
		rdc(8'h85, 8'h00);
		wr(8'h80, 8'h47);
		frame(mk(8'h04), 3);
		i_ctre_host_model.rd(8'h84, g);
		chk(8'(g != 8'hFF), 8'h01);
		wr(8'h80, 8'h53);
		frame(mk(8'h04), 3);
		i_ctre_host_model.rd(8'h84, g);
		chk(8'(g != 8'hFF), 8'h01);
		// two separate touches on each engine in turn
		frame(mk(8'h05), 3);
		rdc(8'h83, 8'h01);
		frame(mk(8'h50), 3);
		chk(liveTouchStatus, 8'h50);
		rdc(8'h83, 8'h02);
		chk(8'(ev2), 8'h01);
		give_verdict();
	end
endmodule // ctre_engine_top_tb

bind ctre_engine_top ctre_engine_asserts #(.NCH(NCH)) i_ctre_engine_asserts (
	.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr),
	.regWrData(regWrData), .regRd(regRd), .regRdData(regRdData),
	.regRdValid(regRdValid), .impValid(impValid), .chanDelay(chanDelay),
	.liveTouchStatus(liveTouchStatus), .sliderEventFlag(sliderEventFlag));
`default_nettype wire
